// [rtl/ats_sequencer.sv]
// Arm/trigger measurement sequencer
`timescale 1ns/1ns
module ats_sequencer
  import ats_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire ats_pkg::ats_cfg_s            cfg,
  input  wire logic                         initiate,
  input  wire logic                         abort,
  input  wire logic [ats_pkg::NUM_SRC-1:0]  src_pins,
  input  wire logic [ats_pkg::NUM_LINES-1:0] line_in,
  output logic [ats_pkg::NUM_LINES-1:0]     line_out,
  output logic [ats_pkg::NUM_LINES-1:0]     line_oe_n,
  output ats_pkg::ats_acq_s                 acq,
  output logic                              armed,
  output logic                              busy,
  output logic                              done,
  output logic [2:0]                        state_code
);
  import ats_pkg::*;

  // ****************************************
  // Input synchronisers and edge history
  // ****************************************
  logic [NUM_SRC-1:0]   src_m;
  logic [NUM_SRC-1:0]   src_s;
  logic [NUM_SRC-1:0]   src_d;
  logic [NUM_LINES-1:0] line_m;
  logic [NUM_LINES-1:0] line_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_m  <= '0;
      src_s  <= '0;
      src_d  <= '0;
      line_m <= '0;
      line_s <= '0;
    end else begin
      src_m  <= src_pins;
      src_s  <= src_m;
      src_d  <= src_s;
      line_m <= line_in;
      line_s <= line_m;
    end
  end

  // Combine enabled sources; no source enabled reads as always satisfied
  function automatic logic combine(input ats_src_cfg_s c, input logic [NUM_SRC-1:0] now,
                                   input logic [NUM_SRC-1:0] prev);
    logic hit;
    logic acc_and;
    logic acc_or;
    acc_and = 1'b1;
    acc_or  = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      case (c.cond[i])
        ATS_HIGH: hit = now[i];
        ATS_LOW:  hit = !now[i];
        ATS_RISE: hit = now[i] && !prev[i];
        ATS_FALL: hit = !now[i] && prev[i];
        default:  hit = 1'b0;
      endcase
      if (c.enable[i]) begin
        acc_and = acc_and & hit;
        acc_or  = acc_or | hit;
      end
    end
    if (c.enable == '0) begin
      return 1'b1;
    end
    return (c.source_combine_op == ATS_OP_AND) ? acc_and : acc_or;
  endfunction

  logic arm_cond;
  logic trig_cond;
  logic start_fall;
  logic sync_seen;
  logic coord_seen;

  assign arm_cond   = combine(cfg.arm_src, src_s, src_d);
  assign trig_cond  = combine(cfg.trig_src, src_s, src_d);
  assign start_fall = !src_s[cfg.start_sel] && src_d[cfg.start_sel];
  assign sync_seen  = |(line_s & cfg.sync_path_select);
  assign coord_seen = |(line_s & cfg.handshake_path_select);

  // ****************************************
  // State machine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP,
    ST_SYNC,
    ST_WAIT_START,
    ST_WAIT_ARM,
    ST_ARM_DELAY,
    ST_WAIT_TRIG,
    ST_STEP
  } ats_state_e;

  ats_state_e       state;
  ats_state_e       step_target;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] holdoff_cnt;
  logic [CNT_W-1:0] guard_cnt;
  logic [CNT_W-1:0] delay_cnt;
  logic             delay_run;
  logic [15:0]      arm_done;
  logic [15:0]      trig_done;
  logic             trig_ok;
  logic             trig_hit;
  logic             last_trig;
  logic             last_arm;
  logic [1:0]       step_age;

  assign trig_ok   = (holdoff_cnt == '0) && (guard_cnt == '0);
  assign trig_hit  = (state == ST_WAIT_TRIG) && trig_ok && trig_cond;
  assign last_trig = (trig_done + 16'h0001) >= cfg.trigger_repeat_total;
  assign last_arm  = (cfg.arm_repeat_total != 16'h0000)
                     && ((arm_done + 16'h0001) >= cfg.arm_repeat_total);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      step_target <= ST_IDLE;
      cnt         <= '0;
      arm_done    <= '0;
      trig_done   <= '0;
      done        <= 1'b0;
    end else if (abort) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      arm_done  <= '0;
      trig_done <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (initiate) begin
            state     <= ST_PREP;
            cnt       <= cfg.settle_cycles;
            done      <= 1'b0;
            arm_done  <= '0;
            trig_done <= '0;
          end
        end
        ST_PREP: begin
          if (cnt != '0) begin
            cnt <= cnt - 32'h0000_0001;
          end else begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (sync_seen || cfg.sync_path_select == '0) begin
            state <= ST_WAIT_START;
          end
        end
        ST_WAIT_START: begin
          if (start_fall) begin
            state       <= ST_STEP;
            step_target <= ST_WAIT_ARM;
          end
        end
        ST_WAIT_ARM: begin
          if (arm_cond) begin
            state <= ST_ARM_DELAY;
            cnt   <= cfg.arm_delay;
          end
        end
        ST_ARM_DELAY: begin
          if (cnt != '0) begin
            cnt <= cnt - 32'h0000_0001;
          end else begin
            state       <= ST_STEP;
            step_target <= ST_WAIT_TRIG;
            trig_done   <= '0;
          end
        end
        ST_WAIT_TRIG: begin
          if (trig_hit) begin
            trig_done <= trig_done + 16'h0001;
            if (last_trig) begin
              arm_done <= arm_done + 16'h0001;
              state    <= ST_STEP;
              if (last_arm) begin
                step_target <= ST_IDLE;
                done        <= 1'b1;
              end else begin
                step_target <= ST_WAIT_ARM;
              end
            end
          end
        end
        ST_STEP: begin
          if (cfg.handshake_path_select == '0 || (coord_seen && step_age == 2'h3)) begin
            state <= step_target;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Holdoff and guard timers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      holdoff_cnt <= '0;
      guard_cnt   <= '0;
    end else if (trig_hit) begin
      holdoff_cnt <= cfg.holdoff;
      guard_cnt   <= GUARD_CYCLES;
    end else begin
      if (holdoff_cnt != '0) holdoff_cnt <= holdoff_cnt - 32'h0000_0001;
      if (guard_cnt != '0) guard_cnt <= guard_cnt - 32'h0000_0001;
    end
  end

  // ****************************************
  // Trigger delay and acquisition start
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      delay_cnt <= '0;
      delay_run <= 1'b0;
      acq       <= '0;
    end else begin
      acq.acq_start <= 1'b0;
      if (trig_hit) begin
        if (cfg.trig_delay[CNT_W-1] || cfg.trig_delay == '0) begin
          acq.acq_start   <= 1'b1;
          acq.pretrig_len <= cfg.trig_delay[CNT_W-1] ? CNT_W'(-cfg.trig_delay) : '0;
        end else begin
          delay_cnt <= CNT_W'(cfg.trig_delay) - 32'h0000_0001;
          delay_run <= 1'b1;
        end
      end else if (delay_run) begin
        if (delay_cnt == '0) begin
          delay_run       <= 1'b0;
          acq.acq_start   <= 1'b1;
          acq.pretrig_len <= '0;
        end else begin
          delay_cnt <= delay_cnt - 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Step age
  // ****************************************
  // Own release needs three cycles to show through the line synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst || abort || state != ST_STEP) begin
      step_age <= '0;
    end else if (step_age != 2'h3) begin
      step_age <= step_age + 2'h1;
    end
  end

  // ****************************************
  // Status and coordination outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed      <= 1'b0;
      busy       <= 1'b0;
      state_code <= 3'h0;
      line_out   <= '0;
      line_oe_n  <= '1;
    end else begin
      armed      <= (state == ST_WAIT_TRIG);
      busy       <= (state != ST_IDLE);
      state_code <= state;
      line_out   <= '0;
      // Busy card holds its handshake lines low until it reaches a step point
      line_oe_n  <= (state != ST_IDLE && state != ST_STEP) ? ~cfg.handshake_path_select : '1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  trig_needs_arm_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    acq.acq_start && !$past(delay_run) |-> $past(state == ST_WAIT_TRIG))
    else $error("acquisition started while not armed");
  guard_blocks_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    trig_hit |=> !trig_hit) else $error("trigger accepted inside guard period");
  holdoff_blocks_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    trig_hit && cfg.holdoff > 32'h2 |=> !trig_hit [*2]) else $error("trigger inside holdoff");
  abort_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    abort |=> state == ST_IDLE) else $error("abort did not return to idle");
  arm_ignored_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    $rose(state == ST_ARM_DELAY) |-> $past(state == ST_WAIT_ARM && arm_cond))
    else $error("arm event taken outside arm wait");
  zero_delay_start_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    trig_hit && cfg.trig_delay == '0 |=> acq.acq_start) else $error("zero delay start missing");
  start_after_prep_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    state == ST_WAIT_START |-> $past(state) inside {ST_SYNC, ST_WAIT_START})
    else $error("start wait entered early");
  immediate_arm_a: assert property (@(posedge clk) disable iff (sys_rst || abort)
    state == ST_WAIT_ARM && cfg.arm_src.enable == '0 |=> state == ST_ARM_DELAY)
    else $error("immediate arm did not arm");
  cover_trig_c: cover property (@(posedge clk) trig_hit);
  cover_done_c: cover property (@(posedge clk) $rose(done));
  cover_pretrig_c: cover property (@(posedge clk) acq.acq_start && acq.pretrig_len != '0);
endmodule

// [rtl/ats_pkg.sv]
// Package of types and constants for the arm/trigger sequencer
package ats_pkg;
  localparam int          NUM_SRC        = 8;
  localparam int          CNT_W          = 32;
  localparam int          NUM_LINES      = 8;
  localparam logic [15:0] ARM_REPEAT_RST = 16'h0001;
  localparam logic [15:0] TRIG_REPEAT_RST = 16'h0001;
  localparam logic [CNT_W-1:0] GUARD_CYCLES = 32'h0000_0001;

  typedef enum logic [1:0] {
    ATS_HIGH,
    ATS_LOW,
    ATS_RISE,
    ATS_FALL
  } ats_cond_e;

  typedef enum logic {
    ATS_OP_AND,
    ATS_OP_OR
  } ats_op_e;

  typedef struct packed {
    logic [NUM_SRC-1:0]         enable;
    ats_cond_e [NUM_SRC-1:0]    cond;
    ats_op_e                    source_combine_op;
  } ats_src_cfg_s;

  typedef struct packed {
    ats_src_cfg_s               arm_src;
    ats_src_cfg_s               trig_src;
    logic [$clog2(NUM_SRC)-1:0] start_sel;
    logic [15:0]                arm_repeat_total;
    logic [15:0]                trigger_repeat_total;
    logic [CNT_W-1:0]           arm_delay;
    logic signed [CNT_W-1:0]    trig_delay;
    logic [CNT_W-1:0]           holdoff;
    logic [CNT_W-1:0]           settle_cycles;
    logic [NUM_LINES-1:0]       sync_path_select;
    logic [NUM_LINES-1:0]       handshake_path_select;
  } ats_cfg_s;

  typedef struct packed {
    logic                       acq_start;
    logic [CNT_W-1:0]           pretrig_len;
  } ats_acq_s;
endpackage

// [testbench/ats_peer_card.sv]
// Peer card model with pulled-up backplane lines
`timescale 1ns/1ns
module ats_peer_card
  import ats_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           kick,
  input  wire logic [15:0]                    hold,
  input  wire logic [ats_pkg::NUM_LINES-1:0]  sel,
  input  wire logic [ats_pkg::NUM_LINES-1:0]  line_oe_n,
  output logic [ats_pkg::NUM_LINES-1:0]       line_in
);
  logic [15:0] cnt;
  // Peer keeps its selected sync and handshake lines low for hold cycles after initiate
  always @(posedge clk) begin
    if (sys_rst) cnt <= 16'h0;
    else if (kick) cnt <= hold;
    else if (cnt != 16'h0) cnt <= cnt - 16'h1;
  end
  // Wired-AND with pull-up: low while either card pulls
  assign line_in = ~(((cnt != 16'h0) ? sel : '0) | ~line_oe_n);
endmodule

// [testbench/tb_ats_sequencer.sv]
// Self-checking bench for the arm/trigger sequencer
`timescale 1ns/1ns
module tb_ats_sequencer;
  import ats_pkg::*;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  ats_cfg_s             cfg = '0;
  ats_cfg_s             c;
  logic                 initiate = 1'b0;
  logic                 abort = 1'b0;
  logic                 kick = 1'b0;
  logic [NUM_SRC-1:0]   src_pins = 8'h80;
  logic [NUM_LINES-1:0] line_in, line_out, line_oe_n;
  ats_acq_s             acq;
  logic                 armed, busy, done;
  logic [2:0]           state_code;
  logic [15:0]          hold = 16'h0;
  int                   miscompares = 0, n_tests = 0, n_acq = 0, d5 = 0;
  int                   t, t1, a, l0, l1;
  int                   dl[3] = '{0, 6, -3};

  ats_sequencer i_ats_sequencer (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .initiate(initiate), .abort(abort),
    .src_pins(src_pins), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n), .acq(acq),
    .armed(armed), .busy(busy), .done(done), .state_code(state_code));
  ats_peer_card i_ats_peer_card (.clk(clk), .sys_rst(sys_rst), .kick(kick), .hold(hold),
    .sel(cfg.sync_path_select | cfg.handshake_path_select), .line_oe_n(line_oe_n), .line_in(line_in));

  initial forever #2 clk = ~clk;

  // Counts acquisitions and cycles spent in the arm delay
  always @(posedge clk) begin
    if (acq.acq_start === 1'b1) n_acq <= n_acq + 1;
    if (state_code === 3'h4) d5 <= 0;
    else if (state_code === 3'h5) d5 <= d5 + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_st(input logic [2:0] s, output int n);
    n = 0;
    while (state_code !== s && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 3000, "state not reached");
  endtask
  task automatic pulse(input int b, input int hi, input int lo);
    @(posedge clk);
    src_pins[b] <= 1'b1;
    w(hi);
    src_pins[b] <= 1'b0;
    w(lo);
  endtask
  task automatic start_fall();
    @(posedge clk);
    src_pins[7] <= 1'b0;
    w(3);
    src_pins[7] <= 1'b1;
  endtask
  task automatic meas(input logic to_trig);
    @(posedge clk);
    cfg <= c;
    @(posedge clk);
    initiate <= 1'b1;
    kick <= 1'b1;
    @(posedge clk);
    initiate <= 1'b0;
    kick <= 1'b0;
    if (to_trig) begin
      wait_st(3'h3, t);
      start_fall();
      wait_st(3'h6, t);
    end
  endtask
  task automatic stop();
    @(posedge clk);
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    w(2);
    @(negedge clk);
    chk(busy === 1'b0 && state_code === 3'h0, "abort did not reach idle");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    t = $urandom(32'h193fc7dc);
    w(3);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk(busy === 1'b0 && done === 1'b0 && state_code === 3'h0 && line_oe_n === 8'hFF, "reset values");
    c = '0;
    c.start_sel = 3'h7;
    c.arm_repeat_total = 16'h1;
    c.trigger_repeat_total = 16'h1;
    c.trig_src.enable = 8'h01;
    for (int i = 0; i < NUM_SRC; i++) c.trig_src.cond[i] = ATS_RISE;
    a = $urandom_range(5, 1);
    c.settle_cycles = a;
    meas(1'b0);
    wait_st(3'h3, t1);
    stop();
    c.settle_cycles = a + 8;
    meas(1'b0);
    wait_st(3'h3, t);
    chk(t - t1 == 8, "preparation time");
    stop();
    c.sync_path_select = 8'h01;
    c.trigger_repeat_total = 16'h4;
    c.holdoff = 6;
    hold = 16'h28;
    meas(1'b0);
    wait_st(3'h3, t);
    chk(t >= 40, "sync wait too short");
    a = n_acq;
    repeat (3) pulse(0, 2, 2);
    w(10);
    @(negedge clk);
    chk(state_code === 3'h3 && n_acq == a, "left start wait");
    start_fall();
    wait_st(3'h6, t);
    chk(armed === 1'b1, "not armed");
    repeat (5) pulse(0, 2, 2);
    w(8);
    @(negedge clk);
    chk(n_acq - a == 3 && done === 1'b0, "holdoff");
    pulse(0, 2, 12);
    @(negedge clk);
    chk(n_acq - a == 4 && done === 1'b1 && busy === 1'b0, "finish");
    hold = 16'h0;
    c.sync_path_select = 8'h00;
    c.trig_src.cond[0] = ATS_HIGH;
    c.holdoff = 0;
    c.trigger_repeat_total = 16'h8;
    meas(1'b1);
    a = n_acq;
    pulse(0, 4, 10);
    chk(n_acq - a == 2, "guard");
    stop();
    c.trig_src.cond[0] = ATS_RISE;
    c.trigger_repeat_total = 16'h1;
    for (int r = 2; r >= 0; r -= 2) begin
      c.arm_repeat_total = 16'(r);
      meas(1'b1);
      a = n_acq;
      repeat (3) pulse(0, 2, 20);
      @(negedge clk);
      chk(n_acq - a == (r == 0 ? 3 : r) && done === (r != 0), "arm repeat");
      stop();
    end
    c.arm_repeat_total = 16'h1;
    c.arm_src.enable = 8'h06;
    c.arm_src.cond[1] = ATS_HIGH;
    c.arm_src.cond[2] = ATS_LOW;
    c.arm_delay = $urandom_range(8, 1);
    for (int op = 0; op < 2; op++) begin
      c.arm_src.source_combine_op = ats_op_e'(op);
      @(posedge clk);
      src_pins[2:1] <= op ? 2'b10 : 2'b11;
      meas(1'b0);
      wait_st(3'h3, t);
      start_fall();
      wait_st(3'h4, t);
      w(20);
      @(negedge clk);
      chk(state_code === 3'h4, "armed too early");
      @(posedge clk);
      src_pins[2:1] <= op ? 2'b00 : 2'b01;
      wait_st(3'h6, t);
      chk(d5 == int'(c.arm_delay) + 1, "arm delay");
      stop();
    end
    c.arm_src.enable = 8'h08;
    for (int k = 0; k < 2; k++) begin
      c.arm_src.cond[3] = k ? ATS_FALL : ATS_RISE;
      @(posedge clk);
      src_pins[3] <= k[0];
      meas(1'b0);
      wait_st(3'h3, t);
      @(posedge clk);
      src_pins[3] <= !k[0];
      start_fall();
      wait_st(3'h4, t);
      w(20);
      @(negedge clk);
      chk(state_code === 3'h4, "early arm edge kept");
      @(posedge clk);
      src_pins[3] <= k[0];
      w(4);
      src_pins[3] <= !k[0];
      wait_st(3'h6, t);
      stop();
    end
    c.arm_src.enable = 8'h00;
    c.trig_src.enable = 8'h03;
    c.trig_src.cond[1] = ATS_HIGH;
    for (int j = 0; j < 3; j++) begin
      c.trig_delay = dl[j];
      meas(1'b1);
      a = n_acq;
      pulse(0, 2, 20);
      chk(n_acq == a, "one source passed the AND");
      @(posedge clk);
      src_pins[1:0] <= 2'b11;
      l1 = 0;
      do begin
        @(negedge clk);
        l1++;
      end while (acq.acq_start !== 1'b1 && l1 < 50);
      if (j == 0) l0 = l1;
      chk(l1 - l0 == (dl[j] > 0 ? dl[j] : 0), "trigger delay");
      chk(acq.pretrig_len === (j == 2 ? 32'h3 : 32'h0), "pre-trigger length");
      @(posedge clk);
      src_pins[1:0] <= 2'b00;
      stop();
    end
    c.handshake_path_select = 8'h02;
    hold = 16'h28;
    meas(1'b0);
    wait_st(3'h3, t);
    @(negedge clk);
    chk(line_oe_n === 8'hFD && line_out === 8'h00, "handshake line not held");
    start_fall();
    wait_st(3'h4, t1);
    chk(t1 >= 20, "step passed before peer");
    wait_st(3'h6, t);
    stop();
    wrap_up();
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
